// file: inc/ccf_defs.vh
// ccf_defs.vh: register offsets, field positions, reset values and timing counts
// for the codec control/flag/filter/headset register bank; included by bare name.
`ifndef CCF_DEFS_VH
`define CCF_DEFS_VH

// register indices as printed; byte address is four times the index
`define CCF_IDX_WORD_OFFSET   8'h0A
`define CCF_IDX_OVF_PLL       8'h0B
`define CCF_IDX_FILTER        8'h0C
`define CCF_IDX_HEADSET_A     8'h0D
// added registers: interrupt status, mask, block inputs view
`define CCF_IDX_IRQ_STATUS    8'h20
`define CCF_IDX_IRQ_MASK      8'h21
`define CCF_IDX_FRAME_CTRL    8'h22

// reset values
`define CCF_RST_WORD_OFFSET   8'h00
`define CCF_RST_PLL_R         4'h1
`define CCF_RST_FILTER        8'h00
`define CCF_RST_HEADSET_A     8'h00

// field positions
`define CCF_OVF_LADC          7
`define CCF_OVF_RADC          6
`define CCF_OVF_LDAC          5
`define CCF_OVF_RDAC          4
`define CCF_HS_EN             7
`define CCF_HS_TYPE_HI        6
`define CCF_HS_TYPE_LO        5
`define CCF_HS_JACK_HI        4
`define CCF_HS_JACK_LO        2
`define CCF_HS_BTN_HI         1
`define CCF_HS_BTN_LO         0

// frame mode: transfer format codes
`define CCF_FMT_I2S           2'h0
`define CCF_FMT_DSP           2'h1

// timing: base tick is 1 ms at 40 MHz
`define CCF_CLK_HZ            40000000
`define CCF_TICK_MS           1
`define CCF_TICK_CYCLES       (`CCF_CLK_HZ / 1000 * `CCF_TICK_MS)
`define CCF_DEB_SAMPLES       8

`endif

// file: logic/ccf_debounce.v
// ccf_debounce.v: debounces one level input on a sample enable pulse.
// assumes the sample enable is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/1ps
`include "ccf_defs.vh"

module ccf_debounce #(
    parameter SAMPLES = `CCF_DEB_SAMPLES
) (
    // clock and reset
    input  wire clk_sys,
    input  wire rst,
    // control
    input  wire enable,
    input  wire bypass,
    input  wire sample_en,
    input  wire raw_in,
    // result
    output reg  state_q
);

    reg [3:0] agree_q;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= 1'b0;
            agree_q <= 4'h0;
        end
        else if (!enable)
        begin
            state_q <= 1'b0;
            agree_q <= 4'h0;
        end
        else if (bypass)
        begin
            state_q <= raw_in;
            agree_q <= 4'h0;
        end
        else if (sample_en)
        begin
            if (raw_in == state_q)
                agree_q <= 4'h0;
            else if (agree_q == SAMPLES - 1)
            begin
                state_q <= raw_in;
                agree_q <= 4'h0;
            end
            else
                agree_q <= agree_q + 4'h1;
        end
    end

endmodule // ccf_debounce

// file: logic/ccf_regs.v
// ccf_regs.v: codec control register bank: word offset, overflow flags,
// digital filter controls, headset detection with debounce; AXI4-Lite slave.
// assumes inputs are synchronous to clk_sys and overflow pulses are one cycle.
`timescale 1ns/1ps
`include "ccf_defs.vh"

module ccf_regs #(
    parameter TICK_CYCLES = `CCF_TICK_CYCLES
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // axi4-lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // codec datapath events and frame context
    input  wire        ovf_ladc,
    input  wire        ovf_radc,
    input  wire        ovf_ldac,
    input  wire        ovf_rdac,
    input  wire [1:0]  xfer_format,
    input  wire        xfer_256clk,
    // headset sensing
    input  wire        jack_stereo_raw,
    input  wire        jack_cell_raw,
    input  wire        button_raw,
    // controls to datapath
    output reg  [7:0]  word_offset,
    output reg         offset_from_wclk_rise,
    output reg         offset_in_range,
    output reg  [3:0]  pll_r,
    output reg  [1:0]  hpf_left,
    output reg  [1:0]  hpf_right,
    output reg         effects_left_en,
    output reg         deemph_left_en,
    output reg         effects_right_en,
    output reg         deemph_right_en,
    output reg         headset_detect_en,
    output reg  [1:0]  headset_type,
    output reg         button_pressed,
    output reg         irq
);

    // registers
    reg [7:0] offset_q;
    reg [3:0] ovf_q;
    reg [3:0] pll_r_q;
    reg [7:0] filter_q;
    reg       hs_en_q;
    reg [2:0] jack_deb_q;
    reg [1:0] btn_deb_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;
    reg       aw_hold_q;
    reg       w_hold_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    // tick generation: 1 ms base, then power-of-two prescale
    reg [31:0] tick_cnt_q;
    reg [6:0]  ms_cnt_q;
    reg        ms_tick_q;
    wire       ms_tick = (tick_cnt_q == TICK_CYCLES - 1);

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_q <= 32'h0;
            ms_cnt_q   <= 7'h0;
            ms_tick_q  <= 1'b0;
        end
        else
        begin
            ms_tick_q <= ms_tick;
            if (ms_tick)
            begin
                tick_cnt_q <= 32'h0;
                ms_cnt_q   <= ms_cnt_q + 7'h1;
            end
            else
                tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // jack sample period 2 ms << code (64 ms for codes 5-7), button 1 ms << (code-1), button code 0 bypassed
    reg [6:0] jack_mask;
    reg [6:0] btn_mask;
    always @*
    begin
        case (jack_deb_q)
            3'h0:    jack_mask = 7'h01;
            3'h1:    jack_mask = 7'h03;
            3'h2:    jack_mask = 7'h07;
            3'h3:    jack_mask = 7'h0F;
            3'h4:    jack_mask = 7'h1F;
            default: jack_mask = 7'h3F;
        endcase
        case (btn_deb_q)
            2'h2:    btn_mask = 7'h01;
            2'h3:    btn_mask = 7'h03;
            default: btn_mask = 7'h00;
        endcase
    end
    wire jack_sample = ms_tick_q && ((ms_cnt_q & jack_mask) == 7'h00);
    wire btn_sample  = ms_tick_q && ((ms_cnt_q & btn_mask) == 7'h00);

    // debouncers, stereo, cellular and button
    wire [2:0] deb_raw = {button_raw, jack_cell_raw, jack_stereo_raw};
    wire [2:0] deb_out;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_deb
            ccf_debounce #(
                .SAMPLES   (`CCF_DEB_SAMPLES)
            ) u_deb (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .enable    (hs_en_q),
                .bypass    ((gi == 2) && (btn_deb_q == 2'h0)),
                .sample_en ((gi == 2) ? btn_sample : jack_sample),
                .raw_in    (deb_raw[gi]),
                .state_q   (deb_out[gi])
            );
        end
    endgenerate

    reg btn_prev_q;
    wire btn_event = deb_out[2] && !btn_prev_q;
    wire [3:0] ovf_in = {ovf_ladc, ovf_radc, ovf_ldac, ovf_rdac};

    // bus decode
    wire [7:0] w_idx = awaddr_q[9:2];
    wire       w_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire       w_hit = (w_idx == `CCF_IDX_WORD_OFFSET) || (w_idx == `CCF_IDX_OVF_PLL) ||
                       (w_idx == `CCF_IDX_FILTER) || (w_idx == `CCF_IDX_HEADSET_A) ||
                       (w_idx == `CCF_IDX_IRQ_STATUS) || (w_idx == `CCF_IDX_IRQ_MASK) ||
                       (w_idx == `CCF_IDX_FRAME_CTRL);
    wire       wr_ok = w_fire && w_hit && (awaddr_q[31:10] == 22'h0) && wstrb_q[0];
    wire [7:0] wd = wdata_q[7:0];
    wire       r_fire = s_axi_arvalid && s_axi_arready;
    wire [7:0] r_idx = s_axi_araddr[9:2];
    wire       r_hi_ok = (s_axi_araddr[31:10] == 22'h0);
    wire       rd_ovf = r_fire && r_hi_ok && (r_idx == `CCF_IDX_OVF_PLL);

    reg [7:0] rd_val;
    reg       rd_hit;
    always @*
    begin
        rd_val = 8'h00;
        rd_hit = r_hi_ok;
        case (r_idx)
            `CCF_IDX_WORD_OFFSET: rd_val = offset_q;
            `CCF_IDX_OVF_PLL:     rd_val = {ovf_q, pll_r_q};
            `CCF_IDX_FILTER:      rd_val = filter_q;
            `CCF_IDX_HEADSET_A:   rd_val = {hs_en_q, headset_type, jack_deb_q, btn_deb_q};
            `CCF_IDX_IRQ_STATUS:  rd_val = {6'h00, irq_status_q};
            `CCF_IDX_IRQ_MASK:    rd_val = {6'h00, irq_mask_q};
            `CCF_IDX_FRAME_CTRL:  rd_val = {5'h00, offset_in_range, xfer_256clk,
                                            offset_from_wclk_rise};
            default:              rd_hit = 1'b0;
        endcase
    end

    // offset limit check per transfer mode
    reg [7:0] offset_max;
    always @*
    begin
        if (xfer_256clk)
            offset_max = (xfer_format == `CCF_FMT_DSP) ? 8'hF1 : 8'hF2;
        else
            offset_max = (xfer_format == `CCF_FMT_DSP) ? 8'h10 : 8'h11;
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h0;
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 32'h0;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            offset_q      <= `CCF_RST_WORD_OFFSET;
            ovf_q         <= 4'h0;
            pll_r_q       <= `CCF_RST_PLL_R;
            filter_q      <= `CCF_RST_FILTER;
            hs_en_q       <= 1'b0;
            jack_deb_q    <= 3'h0;
            btn_deb_q     <= 2'h0;
            irq_status_q  <= 2'h0;
            irq_mask_q    <= 2'h0;
            btn_prev_q    <= 1'b0;
        end
        else
        begin
            // write channels taken independently, response after both
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (w_fire)
            begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (w_hit && (awaddr_q[31:10] == 22'h0)) ? 2'h0 : 2'h2;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;

            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (r_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, rd_val};
                s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;

            // register writes; flag bits and headset type not writable
            if (wr_ok)
            begin
                case (w_idx)
                    `CCF_IDX_WORD_OFFSET: offset_q <= wd;
                    `CCF_IDX_OVF_PLL:     pll_r_q  <= wd[3:0];
                    `CCF_IDX_FILTER:      filter_q <= wd;
                    `CCF_IDX_HEADSET_A:
                    begin
                        hs_en_q    <= wd[`CCF_HS_EN];
                        jack_deb_q <= wd[`CCF_HS_JACK_HI:`CCF_HS_JACK_LO];
                        btn_deb_q  <= wd[`CCF_HS_BTN_HI:`CCF_HS_BTN_LO];
                    end
                    `CCF_IDX_IRQ_MASK:    irq_mask_q <= wd[1:0];
                    default:              irq_mask_q <= irq_mask_q;
                endcase
            end

            // sticky flags: clear on read, new event wins
            ovf_q <= (rd_ovf ? 4'h0 : ovf_q) | ovf_in;

            // interrupt status: bit0 any overflow, bit1 button press
            btn_prev_q <= deb_out[2];
            irq_status_q <= (irq_status_q &
                            ~((wr_ok && (w_idx == `CCF_IDX_IRQ_STATUS)) ? wd[1:0] : 2'h0))
                            | {btn_event, |ovf_in};
        end
    end

    // outputs, all registered
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            word_offset           <= `CCF_RST_WORD_OFFSET;
            offset_from_wclk_rise <= 1'b0;
            offset_in_range       <= 1'b1;
            pll_r                 <= `CCF_RST_PLL_R;
            hpf_left              <= 2'h0;
            hpf_right             <= 2'h0;
            effects_left_en       <= 1'b0;
            deemph_left_en        <= 1'b0;
            effects_right_en      <= 1'b0;
            deemph_right_en       <= 1'b0;
            headset_detect_en     <= 1'b0;
            headset_type          <= 2'h0;
            button_pressed        <= 1'b0;
            irq                   <= 1'b0;
        end
        else
        begin
            word_offset           <= offset_q;
            offset_from_wclk_rise <= (xfer_format == `CCF_FMT_DSP);
            offset_in_range       <= (offset_q <= offset_max);
            pll_r                 <= pll_r_q;
            hpf_left              <= filter_q[7:6];
            hpf_right             <= filter_q[5:4];
            effects_left_en       <= filter_q[3];
            deemph_left_en        <= filter_q[2];
            effects_right_en      <= filter_q[1];
            deemph_right_en       <= filter_q[0];
            headset_detect_en     <= hs_en_q;
            headset_type          <= {deb_out[1], deb_out[0]};
            button_pressed        <= deb_out[2];
            irq                   <= |(irq_status_q & irq_mask_q);
        end
    end

endmodule // ccf_regs

// file: test/ccf_regs_asserts.sv
// ccf_regs_asserts.sv: port-level checks for the codec register bank.
// assumes it is bound to ccf_regs and sees only that module's ports.
`timescale 1ns/1ps
module ccf_regs_asserts (
    // clock and reset
    input wire        clk_sys,
    input wire        rst,
    // bus handshakes
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // frame context and headset
    input wire [1:0]  xfer_format,
    input wire        xfer_256clk,
    input wire [7:0]  word_offset,
    input wire        offset_from_wclk_rise,
    input wire        offset_in_range,
    input wire        headset_detect_en,
    input wire [1:0]  headset_type
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire       dsp = (xfer_format == 2'h1);
    wire [7:0] lim = xfer_256clk ? (dsp ? 8'hF1 : 8'hF2) : (dsp ? 8'h10 : 8'h11);
    chk_dsp_origin: assert property (dsp [*2] |-> offset_from_wclk_rise)
        else $error("offset origin not word clock rise in dsp mode");
    chk_word_origin: assert property (!dsp [*2] |-> !offset_from_wclk_rise)
        else $error("offset origin flagged outside dsp mode");
    chk_range_flag: assert property (($stable(word_offset) && $stable(xfer_format)
        && $stable(xfer_256clk)) [*2] |-> offset_in_range == (word_offset <= lim))
        else $error("offset range flag wrong");
    chk_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer late or upper bits set");
    chk_detect_off: assert property (!headset_detect_en [*3] |-> headset_type == 2'h0)
        else $error("headset type while detection off");
    chk_type_source: assert property ($changed(headset_type)
        |-> $past(headset_detect_en) || headset_type == 2'h0)
        else $error("headset type changed while disabled");
endmodule // ccf_regs_asserts

bind ccf_regs ccf_regs_asserts u_chk (
    .clk_sys(clk_sys), .rst(rst), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .xfer_format(xfer_format), .xfer_256clk(xfer_256clk), .word_offset(word_offset),
    .offset_from_wclk_rise(offset_from_wclk_rise), .offset_in_range(offset_in_range),
    .headset_detect_en(headset_detect_en), .headset_type(headset_type)
);

// file: test/ccf_regs_test.sv
// ccf_regs_test.sv: self-checking bench for the codec register bank.
// assumes ccf_regs with a 4-cycle tick and the bound checker.
`timescale 1ns/1ps
module ccf_regs_test;
    reg         clk_sys, rst, awv, wv, br, arv, rr, x256, jack_s, jack_c, btn;
    reg  [31:0] awaddr, wdata, araddr, rdv;
    reg  [3:0]  ovf;
    reg  [1:0]  fmt, rsp;
    reg  [7:0]  lim;
    wire        awr, wrd, bv, arr, rv, dspr, inr, el, dl, er, dr, hen, bp, irq;
    wire [31:0] rdata;
    wire [1:0]  bresp, rresp, hl, hr, ht;
    wire [7:0]  wo;
    wire [3:0]  pllr;
    integer     failures = 0;
    integer     compares = 0;
    integer     cyc = 0;
    integer     i;

    ccf_regs #(.TICK_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .ovf_ladc(ovf[3]), .ovf_radc(ovf[2]), .ovf_ldac(ovf[1]), .ovf_rdac(ovf[0]),
        .xfer_format(fmt), .xfer_256clk(x256),
        .jack_stereo_raw(jack_s), .jack_cell_raw(jack_c), .button_raw(btn),
        .word_offset(wo), .offset_from_wclk_rise(dspr), .offset_in_range(inr),
        .pll_r(pllr), .hpf_left(hl), .hpf_right(hr), .effects_left_en(el),
        .deemph_left_en(dl), .effects_right_en(er), .deemph_right_en(dr),
        .headset_detect_en(hen), .headset_type(ht), .button_pressed(bp), .irq(irq)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task test_done;
    begin
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // the whole run needs well under this many cycles
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures = failures + 1;
            test_done;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            failures = failures + 1;
        end
    end
    endtask

    task wait_cyc(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask

    // bready stands from the request until bvalid is seen high
    task wr(input [31:0] a, input [7:0] d);
    begin
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        rsp = 2'h3;
        while (rsp == 2'h3)
        begin
            @(posedge clk_sys);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) rsp = bresp;
        end
        br <= 1'b0;
        @(posedge clk_sys);
    end
    endtask

    task rd(input [31:0] a);
    begin
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        rsp = 2'h3;
        while (rsp == 2'h3)
        begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
            if (rv)
            begin
                rsp = rresp;
                rdv = rdata;
            end
        end
        rr <= 1'b0;
        @(posedge clk_sys);
    end
    endtask

    task t_reset;
    begin
        rd(32'h28); chk(rdv, 32'h00);
        chk(rsp, 2'h0);
        rd(32'h2C); chk(rdv, 32'h01);
        rd(32'h30); chk(rdv, 32'h00);
        rd(32'h34); chk(rdv, 32'h00);
    end
    endtask

    task t_offset;
    begin
        wr(32'h28, 8'hFF); rd(32'h28); chk(rdv, 32'hFF);
        chk(wo, 8'hFF);
        for (i = 0; i < 8; i = i + 1)
        begin
            fmt <= i[1:0];
            x256 <= i[2];
            lim = i[2] ? (i[1:0] == 2'h1 ? 8'hF1 : 8'hF2) : (i[1:0] == 2'h1 ? 8'h10 : 8'h11);
            wr(32'h28, lim); wait_cyc(2); chk(inr, 1);
            chk(dspr, i[1:0] == 2'h1);
            wr(32'h28, lim + 8'h01); wait_cyc(2); chk(inr, 0);
        end
    end
    endtask

    task t_ovf;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            ovf <= 4'h1 << i;
            @(posedge clk_sys);
            ovf <= 4'h0;
            wait_cyc(3);
            rd(32'h2C); chk(rdv, (32'h10 << i) | 32'h01);
            rd(32'h2C); chk(rdv, 32'h01);
        end
        wr(32'h2C, 8'hF5); rd(32'h2C); chk(rdv, 32'h05);
        chk(pllr, 4'h5);
        chk(irq, 0);
    end
    endtask

    task t_filter;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(32'h30, 8'h55 * i); rd(32'h30); chk(rdv, 8'h55 * i);
            chk({hl, hr, el, dl, er, dr}, 8'h55 * i);
        end
        wr(32'h30, 8'hC6); chk({hl, hr, el, dl, er, dr}, 8'hC6);
    end
    endtask

    task t_irq;
    begin
        wr(32'h84, 8'h01); wait_cyc(2); chk(irq, 1);
        rd(32'h80); chk(rdv[0], 1);
        wr(32'h80, 8'h01); wait_cyc(2); chk(irq, 0);
        ovf <= 4'h8;
        @(posedge clk_sys);
        ovf <= 4'h0;
        wait_cyc(3); chk(irq, 1);
        wr(32'h80, 8'h01); rd(32'h2C); chk(rdv, 32'h85);
        rd(32'h40); chk(rsp, 2'h2);
        chk(rdv, 0);
        wr(32'h40, 8'h12); chk(rsp, 2'h2);
    end
    endtask

    task t_headset;
    begin
        jack_s <= 1'b1;
        wait_cyc(100); chk(ht, 0);
        wr(32'h34, 8'h81); wait_cyc(40); chk(ht, 0);
        wait_cyc(60); chk(ht, 2'h1);
        rd(32'h34); chk(rdv, 32'hA1);
        btn <= 1'b1;
        wait_cyc(20); chk(bp, 0);
        wait_cyc(30); chk(bp, 1);
        rd(32'h80); chk(rdv, 32'h02);
        wr(32'h34, 8'hF4); rd(32'h34); chk(rdv, 32'hB4);
        btn <= 1'b0;
        wait_cyc(3); chk(bp, 0);
        jack_c <= 1'b1;
        wait_cyc(1500); chk(ht, 2'h1);
        wait_cyc(900); chk(ht, 2'h3);
        wr(32'h34, 8'h14); wait_cyc(3); chk({hen, ht}, 0);
    end
    endtask

    initial
    begin
        rst = 1'b1;
        {awv, wv, br, arv, rr, x256, jack_s, jack_c, btn} = 9'h0;
        {awaddr, wdata, araddr} = 96'h0;
        ovf = 4'h0;
        fmt = 2'h0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        chk(pllr, 4'h1);
        chk(inr, 1);
        t_reset;
        t_offset;
        t_ovf;
        t_filter;
        t_irq;
        t_headset;
        test_done;
    end
endmodule // ccf_regs_test
